/* logic/des_regs.svh */
`ifndef DES_REGS_SVH
`define DES_REGS_SVH

// Avalon word byte offsets
`define DES_OFS_ADDR 8'h00
`define DES_OFS_DATA 8'h04
`define DES_OFS_BANK 8'h08
`define DES_OFS_PTR 8'h0C
`define DES_OFS_PORT 8'h10
`define DES_OFS_FLAG 8'h14
`define DES_OFS_GIE 8'h18

// Control register location behind the indirect port
`define DES_CTL_PTR 8'h40
`define DES_CTL_BANK 8'h01

// Control bits
`define DES_BIT_RD 0
`define DES_BIT_READ_ENABLE 1
`define DES_BIT_WR 2
`define DES_BIT_WRITE_ENABLE 3

// Flag register bits
`define DES_BIT_DEF 0
`define DES_BIT_DEE 1
`define DES_BIT_MFF 2

// Geometry and reset values
`define DES_DEPTH 64
`define DES_AW 6
`define DES_CNT_W 16
`define DES_RST_BYTE 8'h00
`define DES_RST_CTL 4'h0

// Default cycle counts
`define DES_READ_CYCLES 4
`define DES_WRITE_TICKS 8

`endif

/* logic/des_pkg.sv */
`include "des_regs.svh"

package des_pkg;

  typedef enum logic [1:0] {
    DES_IDLE,
    DES_READ,
    DES_WRITE
  } des_phase_t;

  typedef struct packed {
    logic [`DES_DEPTH-1:0][7:0] mem;
    des_phase_t phase;
    logic [`DES_CNT_W-1:0] cnt;
    logic [`DES_AW-1:0] ee_addr;
    logic [7:0] ee_data;
    logic [7:0] bank;
    logic [7:0] ptr;
    logic [3:0] ctl;
    logic def;
    logic dee;
    logic mff;
    logic gie;
    logic waitreq;
    logic [31:0] rdata;
    logic [2:0] sync;
  } des_state_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } des_avs_req_t;

endpackage

/* logic/des_seq.sv */
// Functional notes
// - Control register reachable only with bank select one; zero blocks it.
// - Control register decoded at indirect pointer 040H with bank select 01H.
// - Read enable is bit 1, read start bit 0; both start a read.
// - Data register holds the read byte once read start has cleared.
// - Write enable is bit 3, write start bit 2; both start programming.
// - Write start stays one throughout the whole write cycle.
// - Writing zero to control clears enables and starts, stopping further access; the code clears only the enables, a running start stays set.
// - Hardware clears write start and read start when their cycle ends.
// - A start bit has no effect unless its enable is already one.
// - Write end sets write done flag and multi-function request flag.
//
// Decided for this implementation: the register addresses and the Avalon-MM register port.
`include "des_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module des_seq #(
  parameter int READ_CYCLES = `DES_READ_CYCLES,
  parameter int WRITE_TICKS = `DES_WRITE_TICKS
) (
  input wire logic clk,
  input wire logic reset,
  input wire des_pkg::des_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sub_clk,
  output logic write_done_flag,
  output logic mfi_request,
  output logic global_irq_enable
);

  ////////////////////////////////////////////////////////////////////
  // Parameter checks

  localparam int CNT_MAX = (1 << `DES_CNT_W) - 1;

  if (READ_CYCLES < 1 || READ_CYCLES > CNT_MAX) begin : g_bad_read
    $error("READ_CYCLES out of range");
  end
  if (WRITE_TICKS < 1 || WRITE_TICKS > CNT_MAX) begin : g_bad_write
    $error("WRITE_TICKS out of range");
  end

  localparam logic [`DES_CNT_W-1:0] READ_LAST = `DES_CNT_W'(READ_CYCLES - 1);
  localparam logic [`DES_CNT_W-1:0] WRITE_LAST = `DES_CNT_W'(WRITE_TICKS - 1);

  ////////////////////////////////////////////////////////////////////
  // Decoding

  // Indirect port lands on the control register
  function automatic logic ctl_sel(input logic [7:0] bank, input logic [7:0] ptr);
    ctl_sel = (bank == `DES_CTL_BANK) && (ptr == `DES_CTL_PTR);
  endfunction

  function automatic logic [31:0] rd_word(
    input des_pkg::des_state_t s,
    input logic [7:0] ofs
  );
    rd_word = 32'h0000_0000;
    unique case (ofs)
      `DES_OFS_ADDR: begin
        rd_word[`DES_AW-1:0] = s.ee_addr;
      end
      `DES_OFS_DATA: begin
        rd_word[7:0] = s.ee_data;
      end
      `DES_OFS_BANK: begin
        rd_word[7:0] = s.bank;
      end
      `DES_OFS_PTR: begin
        rd_word[7:0] = s.ptr;
      end
      `DES_OFS_PORT: begin
        if (ctl_sel(s.bank, s.ptr)) begin
          rd_word[3:0] = s.ctl;
        end
      end
      `DES_OFS_FLAG: begin
        rd_word[`DES_BIT_DEF] = s.def;
        rd_word[`DES_BIT_DEE] = s.dee;
        rd_word[`DES_BIT_MFF] = s.mff;
      end
      `DES_OFS_GIE: begin
        rd_word[0] = s.gie;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  des_pkg::des_state_t st_r;
  des_pkg::des_state_t st_nxt;

  logic req;
  logic wr_go;
  logic slow_edge;
  logic [3:0] new_ctl;
  logic idle;

  always_comb begin
    st_nxt = st_r;
    req = avs_req.read || avs_req.write;
    wr_go = avs_req.write && !st_r.waitreq && avs_req.byteenable[0];
    idle = (st_r.phase == des_pkg::DES_IDLE);
    new_ctl = avs_req.writedata[3:0];

    // Slow clock synchroniser and edge detect
    st_nxt.sync = {st_r.sync[1:0], sub_clk};
    slow_edge = st_r.sync[1] && !st_r.sync[2];

    //////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then answer

    st_nxt.waitreq = 1'b1;
    if (req && st_r.waitreq) begin
      st_nxt.waitreq = 1'b0;
      if (avs_req.read) begin
        st_nxt.rdata = rd_word(st_r, avs_req.address);
      end
    end

    //////////////////////////////////////////////////////////////////
    // Software writes

    if (wr_go) begin
      unique case (avs_req.address)
        `DES_OFS_ADDR: begin
          st_nxt.ee_addr = avs_req.writedata[`DES_AW-1:0];
        end
        `DES_OFS_DATA: begin
          st_nxt.ee_data = avs_req.writedata[7:0];
        end
        `DES_OFS_BANK: begin
          st_nxt.bank = avs_req.writedata[7:0];
        end
        `DES_OFS_PTR: begin
          st_nxt.ptr = avs_req.writedata[7:0];
        end
        `DES_OFS_PORT: begin
          if (ctl_sel(st_r.bank, st_r.ptr)) begin
            st_nxt.ctl[`DES_BIT_WRITE_ENABLE] = new_ctl[`DES_BIT_WRITE_ENABLE];
            st_nxt.ctl[`DES_BIT_READ_ENABLE] = new_ctl[`DES_BIT_READ_ENABLE];
            if (idle) begin
              // Start bits honour only the enable already stored
              if (new_ctl[`DES_BIT_WR] && st_r.ctl[`DES_BIT_WRITE_ENABLE]) begin
                st_nxt.ctl[`DES_BIT_WR] = 1'b1;
                st_nxt.phase = des_pkg::DES_WRITE;
                st_nxt.cnt = '0;
              end else if (new_ctl[`DES_BIT_RD] && st_r.ctl[`DES_BIT_READ_ENABLE]) begin
                st_nxt.ctl[`DES_BIT_RD] = 1'b1;
                st_nxt.phase = des_pkg::DES_READ;
                st_nxt.cnt = '0;
              end
            end
          end
        end
        `DES_OFS_FLAG: begin
          st_nxt.def = avs_req.writedata[`DES_BIT_DEF];
          st_nxt.dee = avs_req.writedata[`DES_BIT_DEE];
          st_nxt.mff = avs_req.writedata[`DES_BIT_MFF];
        end
        `DES_OFS_GIE: begin
          st_nxt.gie = avs_req.writedata[0];
        end
        default: begin
        end
      endcase
    end

    //////////////////////////////////////////////////////////////////
    // Access cycles; hardware updates override software clears

    unique case (st_r.phase)
      des_pkg::DES_IDLE: begin
      end
      des_pkg::DES_READ: begin
        st_nxt.ctl[`DES_BIT_RD] = 1'b1;
        st_nxt.cnt = st_r.cnt + `DES_CNT_W'(1);
        if (st_r.cnt == READ_LAST) begin
          st_nxt.ee_data = st_r.mem[st_r.ee_addr];
          st_nxt.ctl[`DES_BIT_RD] = 1'b0;
          st_nxt.phase = des_pkg::DES_IDLE;
          st_nxt.cnt = '0;
        end
      end
      des_pkg::DES_WRITE: begin
        st_nxt.ctl[`DES_BIT_WR] = 1'b1;
        if (slow_edge) begin
          st_nxt.cnt = st_r.cnt + `DES_CNT_W'(1);
          if (st_r.cnt == WRITE_LAST) begin
            st_nxt.mem[st_r.ee_addr] = st_r.ee_data;
            st_nxt.ctl[`DES_BIT_WR] = 1'b0;
            st_nxt.def = 1'b1;
            st_nxt.mff = 1'b1;
            st_nxt.phase = des_pkg::DES_IDLE;
            st_nxt.cnt = '0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
      st_r.waitreq <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.waitreq;
  assign write_done_flag = st_r.def;
  assign mfi_request = st_r.mff;
  assign global_irq_enable = st_r.gie;

endmodule

`default_nettype wire

/* tb/des_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module des_chk #(parameter int WRITE_TICKS = 2) (
  input wire logic clk,
  input wire logic reset,
  input wire des_pkg::des_avs_req_t avs_req,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic sub_clk,
  input wire logic write_done_flag,
  input wire logic mfi_request,
  input wire logic global_irq_enable
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic wa, fa, sq_r, fq_r;
  int tk_r;
  assign wa = !avs_waitrequest && avs_req.write && avs_req.byteenable[0];
  assign fa = wa && avs_req.address == 8'h14;
  ////////////////////////////////////////////////////////////////
  // Slow clock rises since the last write end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sq_r <= 1'b0;
      fq_r <= 1'b0;
      tk_r <= 0;
    end else begin
      sq_r <= sub_clk;
      fq_r <= write_done_flag;
      if (write_done_flag && !fq_r)
        tk_r <= 0;
      else if (sub_clk && !sq_r)
        tk_r <= tk_r + 1;
    end
  end
  ////////////////////////////////////////////////////////////////
  chk_bus_answer: assert property ((avs_req.read || avs_req.write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus not answered");
  chk_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack too long");
  chk_gie_set: assert property (wa && avs_req.address == 8'h18
    |=> global_irq_enable == $past(avs_req.writedata[0])) else $error("gie not written");
  chk_gie_hold: assert property (!(wa && avs_req.address == 8'h18)
    |=> $stable(global_irq_enable)) else $error("gie changed");
  chk_flag_pair: assert property ($rose(write_done_flag) && !$past(fa) |-> mfi_request)
    else $error("request flag missing");
  chk_flag_hold: assert property (write_done_flag && !fa |=> write_done_flag)
    else $error("done flag lost");
  chk_ctl_width: assert property (!avs_waitrequest && avs_req.read &&
    avs_req.address == 8'h10 |-> avs_readdata[31:4] == 28'h0) else $error("control too wide");
  chk_write_ticks: assert property ($rose(write_done_flag) |-> tk_r >= WRITE_TICKS)
    else $error("write ended early");
endmodule
bind des_seq des_chk #(.WRITE_TICKS(WRITE_TICKS)) u_chk (.clk(clk), .reset(reset),
  .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .sub_clk(sub_clk), .write_done_flag(write_done_flag), .mfi_request(mfi_request),
  .global_irq_enable(global_irq_enable));
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sub_clk = 1'b0;
  des_pkg::des_avs_req_t req = '0;
  logic [31:0] rdata, q;
  logic wrq, flag, mfi, gie;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int mem [64];
  int a, d;
  always #5 clk = ~clk;
  des_seq #(.READ_CYCLES(2), .WRITE_TICKS(2)) u_dut (.clk(clk), .reset(reset),
    .avs_req(req), .avs_readdata(rdata), .avs_waitrequest(wrq), .sub_clk(sub_clk),
    .write_done_flag(flag), .mfi_request(mfi), .global_irq_enable(gie));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares=%0d errors=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] wd);
    @(posedge clk);
    req.address <= ad;
    req.read <= !w;
    req.write <= w;
    req.byteenable <= 4'hF;
    req.writedata <= wd;
    // Values seen here are those settled before the edge
    do @(posedge clk); while (wrq !== 1'b0);
    q = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    bus(ad, 1'b1, wd);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
    bus(ad, 1'b0, 32'h0);
    chk(q, ex);
  endtask
  // Slow clock only runs while polling
  task automatic poll(input int b);
    do begin
      sub_clk <= ~sub_clk;
      bus(8'h10, 1'b0, 32'h0);
    end while (q[b] !== 1'b0);
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    a = $urandom(86376);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(8'h14, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h40);
    wr(8'h10, 32'h4);
    rd(8'h10, 32'h0);
    wr(8'h10, 32'h1);
    rd(8'h10, 32'h0);
    for (int i = 0; i < 3; i++) begin
      a = (i == 2) ? 63 : $urandom % 64;
      d = $urandom % 256;
      wr(8'h00, 32'(a));
      wr(8'h04, 32'(d));
      wr(8'h18, 32'h0);
      wr(8'h10, 32'h8);
      wr(8'h10, 32'hC);
      wr(8'h18, 32'h1);
      @(posedge clk);
      chk({31'h0, gie}, 32'h1);
      rd(8'h10, 32'hC);
      poll(2);
      mem[a] = d;
      chk(q, 32'h8);
      rd(8'h14, 32'h5);
      wr(8'h14, 32'h0);
      wr(8'h10, 32'h0);
      rd(8'h10, 32'h0);
      wr(8'h04, 32'h0);
      wr(8'h10, 32'h2);
      wr(8'h10, 32'h3);
      poll(0);
      chk(q, 32'h2);
      rd(8'h04, 32'(mem[a]));
      wr(8'h10, 32'h0);
    end
    wr(8'h08, 32'h0);
    wr(8'h10, 32'h8);
    rd(8'h10, 32'h0);
    wr(8'h08, 32'h1);
    wr(8'h0C, 32'h41);
    wr(8'h10, 32'h8);
    rd(8'h10, 32'h0);
    wr(8'h0C, 32'h40);
    rd(8'h10, 32'h0);
    rd(8'h1C, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
